// ### src/uart_regsel_map.svh
// register offsets, field positions, reset values and pin idle levels
// Behaviour
// - modem control bit 4 enables loopback
// - loopback feeds transmit shifter into receiver
// - loopback holds transmit mark, modem outputs off
// - loopback ignores external modem input pins
// - auto flow control disabled during loopback
// - own register set, address and chip select
// - address 0 normal: receive read, transmit write
// - divisor latch bytes when divisor access set
// - zero divisor returns revision and identification
// - line control always reachable at address 3
// - value 0xbf selects enhanced register set
// - address 7 scratchpad or fifo level select
// - address 7 swapped writes mode select
// - addresses 2 and 4 to 7 normal set in divisor mode
// - line and modem status read only
// - enhanced bits gated by enhanced enable
`ifndef UART_REGSEL_MAP_SVH
`define UART_REGSEL_MAP_SVH

// register addresses on the three address lines
`define ADDR_0          3'h0
`define ADDR_1          3'h1
`define ADDR_2          3'h2
`define ADDR_3          3'h3
`define ADDR_4          3'h4
`define ADDR_5          3'h5
`define ADDR_6          3'h6
`define ADDR_7          3'h7

// line control value that opens the enhanced set
`define LINE_CTRL_ENH   8'hbf
// field positions
`define DIV_ACCESS_BIT  7
`define LOOPBACK_BIT    4
`define SCPAD_SWAP_BIT  6
`define ENH_ENABLE_BIT  4
`define AUTO_CTS_BIT    7
`define AUTO_RTS_BIT    6
`define RTS_CTRL_BIT    1
`define DTR_CTRL_BIT    0
`define OP1_BIT         2
`define OP2_BIT         3

// masks of the bits gated by the enhanced enable
`define IER_ENH_MASK    8'hf0
`define ISR_ENH_MASK    8'h30
`define FCR_ENH_MASK    8'h30
`define MCR_ENH_MASK    8'he0

// reset values
`define RST_BYTE        8'h00
`define RST_LINE_CTRL   8'h00
`define ZERO_BYTE       8'h00
// pin idle: strobes, select, rx and modem inputs high
`define PIN_IDLE        19'h7f800

`endif

// ### src/uart_regsel_pkg.sv
// types shared by the channel register select and loopback block
package uart_regsel_pkg;

    // modem inputs, all active low
    typedef struct packed {
        logic cts_n;
        logic dsr_n;
        logic cd_n;
        logic ri_n;
    } modem_in_s;

    // every pin input, bundled for the synchroniser
    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic       rx;
        modem_in_s  modem;
        logic [2:0] addr;
        logic [7:0] data;
    } pin_s;

    // software programmed configuration
    typedef struct packed {
        logic [7:0] divisor_low;
        logic [7:0] divisor_high;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] interrupt_enable;
        logic [7:0] feature_control;
        logic [7:0] enhanced_function;
        logic [7:0] xon_char_1;
        logic [7:0] xon_char_2;
        logic [7:0] xoff_char_1;
        logic [7:0] xoff_char_2;
        logic [7:0] scratchpad;
    } cfg_s;

    // read values supplied by the rest of the channel
    typedef struct packed {
        logic [7:0] receive_holding;
        logic [7:0] interrupt_status;
        logic [7:0] line_status;
        logic [7:0] modem_status;
        logic [7:0] fifo_level;
        logic [7:0] fifo_level_count_enhanced;
    } status_s;

    // one-cycle access strobes toward the channel
    typedef struct packed {
        logic tx_write;
        logic fifo_control_write;
        logic trigger_write;
        logic mode_select_write;
        logic rx_read;
        logic isr_read;
        logic lsr_read;
        logic msr_read;
    } strobe_s;

endpackage

// ### src/uart_register_select_loopback.sv
// one channel: host register decode plus internal loopback routing
`timescale 1ns/1ps
`include "uart_regsel_map.svh"

module uart_register_select_loopback
    import uart_regsel_pkg::*;
#(
    parameter logic [7:0] REVISION_CODE  = 8'h01, // arbitrary value
    parameter logic [7:0] DEVICE_ID_CODE = 8'h5c  // arbitrary value
) (
    // clock and reset
    input  wire logic      sys_clk,
    input  wire logic      rst,
    // host parallel bus pins
    input  wire logic      chip_select_n,
    input  wire logic      read_strobe_n,
    input  wire logic      write_strobe_n,
    input  wire logic [2:0] address,
    input  wire logic [7:0] host_data_in,
    output logic      [7:0] host_data_out,
    output logic            host_data_oe_n,
    // serial and modem pins
    input  wire logic      rx_pin,
    input  modem_in_s      modem_pins,
    output logic           tx_pin,
    output logic           rts_n_pin,
    output logic           dtr_n_pin,
    // transmitter and receiver shifters
    input  wire logic      tx_shift_out,
    output logic           rx_shift_in,
    output modem_in_s      modem_to_status,
    // channel state to read back
    input  status_s        status,
    // configuration and strobes toward the channel
    output cfg_s           cfg,
    output strobe_s        strobe,
    output logic      [7:0] write_byte,
    output logic           loopback,
    output logic           auto_cts_enable,
    output logic           auto_rts_enable
);

    // whole state of the block
    typedef struct packed {
        pin_s [2:0] stage;   // three-deep pin synchroniser
        pin_s       filt;    // level once stages two and three agree
        logic       rd_act;  // host read cycle in progress
        logic       wr_act;  // host write cycle in progress
        logic [2:0] waddr;   // address held during a write
        logic [7:0] wdata;   // data held during a write
        cfg_s       cfg;     // programmed registers
        strobe_s    strobe;  // one-cycle side effect pulses
        logic [7:0] wbyte;   // byte handed with a write strobe
        logic [7:0] rdata;   // byte driven onto the host bus
    } state_s;

    state_s st_reg;          // registered state
    state_s st_next;         // next state

    // decode helpers, from registered state and the status inputs
    logic       div_access;  // divisor access bit
    logic       enh_set;     // enhanced set open
    logic       enh_bits;    // enhanced bits enabled
    logic       div_zero;    // both divisor bytes zero
    logic       swap;        // scratchpad swap
    logic       rd_now;      // read strobe qualified
    logic       wr_now;      // write strobe qualified
    logic       wr_end;      // write strobe released
    logic [18:0] agree;      // stage two equals stage three
    logic [7:0] rmux;        // read value for current address
    logic [7:0] ier_view;    // interrupt enable as seen
    logic [7:0] isr_view;    // interrupt status as seen
    logic [7:0] mcr_view;    // modem control as seen
    cfg_s       cfg_new;     // configuration after a write

    // mode decode
    always_comb begin
        div_access = st_reg.cfg.line_control[`DIV_ACCESS_BIT];
        enh_set    = (st_reg.cfg.line_control == `LINE_CTRL_ENH);
        enh_bits   = st_reg.cfg.enhanced_function[`ENH_ENABLE_BIT];
        div_zero   = (st_reg.cfg.divisor_low == `ZERO_BYTE)
                   && (st_reg.cfg.divisor_high == `ZERO_BYTE);
        swap       = st_reg.cfg.feature_control[`SCPAD_SWAP_BIT];
        // each channel answers only its own select
        rd_now     = !st_reg.filt.cs_n && !st_reg.filt.rd_n;
        wr_now     = !st_reg.filt.cs_n && !st_reg.filt.wr_n;
        wr_end     = st_reg.wr_act && !wr_now;
    end

    // enhanced bits read as zero unless enabled
    always_comb begin
        ier_view = st_reg.cfg.interrupt_enable;
        isr_view = status.interrupt_status;
        mcr_view = st_reg.cfg.modem_control;
        if (!enh_bits) begin
            ier_view = ier_view & ~`IER_ENH_MASK;
            isr_view = isr_view & ~`ISR_ENH_MASK;
            mcr_view = mcr_view & ~`MCR_ENH_MASK;
        end
    end

    // read multiplexer, one full byte per access
    always_comb begin
        rmux = `ZERO_BYTE;
        unique case (st_reg.filt.addr)
            `ADDR_0: begin
                if (enh_set) begin
                    rmux = status.fifo_level_count_enhanced;
                end else if (div_access && div_zero) begin
                    rmux = REVISION_CODE;
                end else if (div_access) begin
                    rmux = st_reg.cfg.divisor_low;
                end else begin
                    rmux = status.receive_holding;
                end
            end
            `ADDR_1: begin
                if (enh_set) begin
                    rmux = st_reg.cfg.feature_control;
                end else if (div_access && div_zero) begin
                    rmux = DEVICE_ID_CODE;
                end else if (div_access) begin
                    rmux = st_reg.cfg.divisor_high;
                end else begin
                    rmux = ier_view;
                end
            end
            `ADDR_2: begin
                if (enh_set) begin
                    rmux = st_reg.cfg.enhanced_function;
                end else begin
                    rmux = isr_view;
                end
            end
            `ADDR_3: begin
                rmux = st_reg.cfg.line_control;
            end
            `ADDR_4: begin
                // divisor mode leaves the upper addresses at the normal set
                rmux = enh_set ? st_reg.cfg.xon_char_1 : mcr_view;
            end
            `ADDR_5: begin
                rmux = enh_set ? st_reg.cfg.xon_char_2
                               : status.line_status;
            end
            `ADDR_6: begin
                rmux = enh_set ? st_reg.cfg.xoff_char_1
                               : status.modem_status;
            end
            `ADDR_7: begin
                if (enh_set) begin
                    rmux = st_reg.cfg.xoff_char_2;
                end else if (swap) begin
                    rmux = status.fifo_level;
                end else begin
                    rmux = st_reg.cfg.scratchpad;
                end
            end
        endcase
    end

    // register update for a write at the held address
    always_comb begin
        cfg_new = st_reg.cfg;
        unique case (st_reg.waddr)
            `ADDR_0: begin
                if (!enh_set && div_access) begin
                    cfg_new.divisor_low = st_reg.wdata;
                end
            end
            `ADDR_1: begin
                if (enh_set) begin
                    cfg_new.feature_control = st_reg.wdata;
                end else if (div_access) begin
                    cfg_new.divisor_high = st_reg.wdata;
                end else begin
                    cfg_new.interrupt_enable = st_reg.wdata;
                end
            end
            `ADDR_2: begin
                if (enh_set) begin
                    cfg_new.enhanced_function = st_reg.wdata;
                end
            end
            `ADDR_3: begin
                cfg_new.line_control = st_reg.wdata;
            end
            `ADDR_4: begin
                if (enh_set) begin
                    cfg_new.xon_char_1 = st_reg.wdata;
                end else begin
                    cfg_new.modem_control = st_reg.wdata;
                end
            end
            `ADDR_5: begin
                // normal set: reserved, write discarded
                if (enh_set) begin
                    cfg_new.xon_char_2 = st_reg.wdata;
                end
            end
            `ADDR_6: begin
                if (enh_set) begin
                    cfg_new.xoff_char_1 = st_reg.wdata;
                end
            end
            `ADDR_7: begin
                if (enh_set) begin
                    cfg_new.xoff_char_2 = st_reg.wdata;
                end else if (!swap) begin
                    cfg_new.scratchpad = st_reg.wdata;
                end
            end
        endcase
    end

    // next state
    always_comb begin
        st_next = st_reg;
        st_next.strobe = '0;
        // shift pins in; stage one feeds stage two only
        st_next.stage[0] = {chip_select_n, read_strobe_n, write_strobe_n,
                            rx_pin, modem_pins, address, host_data_in};
        st_next.stage[1] = st_reg.stage[0];
        st_next.stage[2] = st_reg.stage[1];
        // a change counts once stages two and three agree
        agree = st_reg.stage[1] ~^ st_reg.stage[2];
        st_next.filt = pin_s'((agree & st_reg.stage[2])
                            | (~agree & st_reg.filt));
        st_next.rd_act = rd_now;
        st_next.wr_act = wr_now;

        // read opening: capture byte and fire side effects
        if (rd_now && !st_reg.rd_act) begin
            st_next.rdata = rmux;
            unique case (st_reg.filt.addr)
                `ADDR_0: begin
                    st_next.strobe.rx_read = !enh_set && !div_access;
                end
                `ADDR_2: begin
                    st_next.strobe.isr_read = !enh_set;
                end
                `ADDR_5: begin
                    st_next.strobe.lsr_read = !enh_set;
                end
                `ADDR_6: begin
                    st_next.strobe.msr_read = !enh_set;
                end
                default: begin
                    st_next.strobe.rx_read = 1'b0;
                end
            endcase
        end

        // hold address and data while the write strobe is low
        if (wr_now) begin
            st_next.waddr = st_reg.filt.addr;
            st_next.wdata = st_reg.filt.data;
        end

        // commit on strobe release, data settled by then
        if (wr_end) begin
            st_next.cfg   = cfg_new;
            st_next.wbyte = st_reg.wdata;
            unique case (st_reg.waddr)
                `ADDR_0: begin
                    st_next.strobe.tx_write = !enh_set && !div_access;
                    st_next.strobe.trigger_write = enh_set;
                end
                `ADDR_2: begin
                    st_next.strobe.fifo_control_write = !enh_set;
                    if (!enh_set && !enh_bits) begin
                        st_next.wbyte = st_reg.wdata & ~`FCR_ENH_MASK;
                    end
                end
                `ADDR_7: begin
                    st_next.strobe.mode_select_write = !enh_set && swap;
                end
                default: begin
                    st_next.strobe.tx_write = 1'b0;
                end
            endcase
        end
    end

    // single state register, constants only under reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_reg        <= '0;
            st_reg.stage  <= {3{pin_s'(`PIN_IDLE)}};
            st_reg.filt   <= pin_s'(`PIN_IDLE);
            st_reg.cfg.line_control <= `RST_LINE_CTRL;
            st_reg.rdata  <= `RST_BYTE;
        end else begin
            st_reg <= st_next;
        end
    end

    // host bus outputs; driver on only inside a read cycle
    assign host_data_out  = st_reg.rdata;
    assign host_data_oe_n = !st_reg.rd_act;

    // configuration seen by the channel, enhanced bits gated
    always_comb begin
        cfg = st_reg.cfg;
        cfg.interrupt_enable = ier_view;
        cfg.modem_control    = mcr_view;
    end
    assign strobe     = st_reg.strobe;
    assign write_byte = st_reg.wbyte;

    // loopback leaves every other function running except auto flow control
    assign loopback = st_reg.cfg.modem_control[`LOOPBACK_BIT];

    // receiver input: shifter output in loopback
    // rx pin unused then; a low level there shows on exit
    assign rx_shift_in = loopback ? tx_shift_out : st_reg.filt.rx;

    // pins parked: mark on tx, modem outputs high
    assign tx_pin    = loopback ? 1'b1 : tx_shift_out;
    assign rts_n_pin = loopback ? 1'b1
                     : !st_reg.cfg.modem_control[`RTS_CTRL_BIT];
    assign dtr_n_pin = loopback ? 1'b1
                     : !st_reg.cfg.modem_control[`DTR_CTRL_BIT];

    // external modem inputs ignored; internal outputs looped back
    always_comb begin
        modem_to_status = st_reg.filt.modem;
        if (loopback) begin
            modem_to_status.cts_n = !st_reg.cfg.modem_control[`RTS_CTRL_BIT];
            modem_to_status.dsr_n = !st_reg.cfg.modem_control[`DTR_CTRL_BIT];
            modem_to_status.ri_n  = !st_reg.cfg.modem_control[`OP1_BIT];
            modem_to_status.cd_n  = !st_reg.cfg.modem_control[`OP2_BIT];
        end
    end

    // hardware flow control is unsupported while looped back
    assign auto_cts_enable = st_reg.cfg.enhanced_function[`AUTO_CTS_BIT]
                          && !loopback;
    assign auto_rts_enable = st_reg.cfg.enhanced_function[`AUTO_RTS_BIT]
                          && !loopback;

endmodule

// ### tb/uart_regsel_checker.sv
// port-level assertions for the channel register select and loopback block
`timescale 1ns/1ps
module uart_regsel_checker
    import uart_regsel_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // host bus
    input  wire logic chip_select_n,
    input  wire logic read_strobe_n,
    input  wire logic host_data_oe_n,
    // serial and modem
    input  wire logic tx_shift_out,
    input  wire logic tx_pin,
    input  wire logic rts_n_pin,
    input  wire logic dtr_n_pin,
    input  wire logic rx_shift_in,
    input  modem_in_s modem_to_status,
    // channel side
    input  cfg_s      cfg,
    input  strobe_s   strobe,
    input  wire logic loopback,
    input  wire logic auto_cts_enable,
    input  wire logic auto_rts_enable
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    chk_loop_bit_map: assert property (loopback == cfg.modem_control[4])
        else $error("loopback differs from modem control bit 4");
    chk_tx_follow: assert property (!loopback |-> tx_pin == tx_shift_out)
        else $error("transmit pin not following shifter");
    chk_loop_route: assert property (loopback |-> rx_shift_in == tx_shift_out)
        else $error("receiver not fed from transmitter in loopback");
    chk_loop_mark: assert property (loopback |-> tx_pin && rts_n_pin && dtr_n_pin)
        else $error("pins not idle in loopback");
    chk_loop_modem_in: assert property (loopback |-> modem_to_status ==
        {~cfg.modem_control[1], ~cfg.modem_control[0],
         ~cfg.modem_control[3], ~cfg.modem_control[2]})
        else $error("external modem inputs reach status in loopback");
    chk_loop_no_flow: assert property (loopback |-> !auto_cts_enable && !auto_rts_enable)
        else $error("auto flow control active in loopback");
    chk_enh_gate: assert property (!cfg.enhanced_function[4] |->
        cfg.interrupt_enable[7:4] == 4'h0 && cfg.modem_control[7:5] == 3'h0)
        else $error("enhanced bits visible while disabled");
    chk_tx_pulse_one: assert property (strobe.tx_write |=> !strobe.tx_write)
        else $error("transmit write pulse longer than one cycle");
    chk_oe_cause: assert property ($fell(host_data_oe_n) |->
        !read_strobe_n && !chip_select_n)
        else $error("bus driven without a selected read");
    chk_oe_release: assert property ($rose(read_strobe_n) |-> ##[1:8] host_data_oe_n)
        else $error("bus still driven after read ended");
endmodule

bind uart_register_select_loopback uart_regsel_checker u_uart_regsel_checker (
    .sys_clk, .rst, .chip_select_n, .read_strobe_n, .host_data_oe_n, .tx_shift_out,
    .tx_pin, .rts_n_pin, .dtr_n_pin, .rx_shift_in, .modem_to_status, .cfg, .strobe,
    .loopback, .auto_cts_enable, .auto_rts_enable);

// ### tb/host_bus_model.sv
// host processor model driving one channel's parallel bus pins
`timescale 1ns/1ps
module host_bus_model (
    // clock
    input  wire logic       sys_clk,
    // bus pins toward the device
    output logic            cs_n,
    output logic            rd_n,
    output logic            wr_n,
    output logic [2:0]      addr,
    output logic [7:0]      dout,
    // device answer
    input  wire logic [7:0] din,
    input  wire logic       oe_n,
    // serial line toward the device
    output logic            rx_pin
);
    // idle bus at time zero
    initial begin
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        addr = 3'h0;
        dout = 8'h00;
        rx_pin = 1'b1; // marking line, avoids a false break after loopback
    end

    // one access; strobes held at least six cycles so the filter sees them
    task automatic xfer(input logic wr, input logic sel, input logic [2:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        int n;
        q = 8'hxx; // unanswered read stays unknown
        n = 0;
        @(posedge sys_clk);
        #2;
        addr = a;
        dout = d;
        cs_n = ~sel;
        rd_n = wr;
        wr_n = ~wr;
        while (n < 12 && !(n >= 6 && (wr || !sel || oe_n === 1'b0))) begin
            @(posedge sys_clk);
            #2;
            n++;
        end
        if (!wr && oe_n === 1'b0) q = din;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        // address and data held past release, then spacing
        repeat (8) @(posedge sys_clk);
        #2;
        dout = ~dout; // released data no longer shows the last byte
    endtask
endmodule

// ### tb/testbench.sv
// self-checking bench for the channel register select and loopback block
`timescale 1ns/1ps
module testbench;
    import uart_regsel_pkg::*;
    localparam logic [7:0] REV = 8'h3c; // arbitrary value
    localparam logic [7:0] DID = 8'h71; // arbitrary value
    logic       sys_clk, rst, cs_n, rd_n, wr_n, rx_pin, oe_n;
    logic       tx_shift_out, rx_shift_in, tx_pin, rts_n, dtr_n, loopback, acts, arts;
    logic [2:0] addr;
    logic [7:0] hdin, hdout, wbyte, r, last_wb, last_fc, junk;
    logic [7:0] x [4:7];
    logic [31:0] r32;
    modem_in_s  modem_pins, modem_to_status;
    status_s    status;
    cfg_s       cfg, c0;
    strobe_s    strobe;
    int         seed = 32'ha55cb8fb;
    int         fail_count = 0, total_checks = 0, tx_cnt = 0, ms_cnt = 0, tg_cnt = 0, rp_cnt = 0;

    uart_register_select_loopback #(.REVISION_CODE(REV), .DEVICE_ID_CODE(DID))
    u_uart_register_select_loopback (
        .sys_clk(sys_clk), .rst(rst), .chip_select_n(cs_n), .read_strobe_n(rd_n),
        .write_strobe_n(wr_n), .address(addr), .host_data_in(hdin),
        .host_data_out(hdout), .host_data_oe_n(oe_n), .rx_pin(rx_pin),
        .modem_pins(modem_pins), .tx_pin(tx_pin), .rts_n_pin(rts_n), .dtr_n_pin(dtr_n),
        .tx_shift_out(tx_shift_out), .rx_shift_in(rx_shift_in),
        .modem_to_status(modem_to_status), .status(status), .cfg(cfg), .strobe(strobe),
        .write_byte(wbyte), .loopback(loopback), .auto_cts_enable(acts),
        .auto_rts_enable(arts));

    host_bus_model u_host_bus_model (.sys_clk(sys_clk), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .addr(addr), .dout(hdin), .din(hdout), .oe_n(oe_n), .rx_pin(rx_pin));

    // clock
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // random shifter bit and modem pins every cycle
    always @(posedge sys_clk) begin
        #2;
        r32 = $random(seed);
        tx_shift_out = r32[0];
        modem_pins = r32[4:1];
    end
    // pulse monitor at the falling edge, where pulses are settled
    always @(negedge sys_clk) begin
        if (strobe.tx_write === 1'b1) begin
            tx_cnt++;
            last_wb = wbyte;
        end
        if (strobe.mode_select_write === 1'b1) ms_cnt++;
        if (strobe.trigger_write === 1'b1) tg_cnt++;
        if (strobe.fifo_control_write === 1'b1) last_fc = wbyte;
        if (|{strobe.rx_read, strobe.isr_read, strobe.lsr_read, strobe.msr_read}) rp_cnt++;
    end

    task chk(input logic [95:0] got, input logic [95:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wr(input logic [2:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host_bus_model.xfer(1'b1, 1'b1, a, d, q);
    endtask
    task rd(input logic [2:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host_bus_model.xfer(1'b0, 1'b1, a, 8'h00, q);
        chk(q, e);
    endtask
    // status bits 5:4 read as zero while enhanced bits are off
    function automatic logic [7:0] isr_exp(input logic enh, input logic [7:0] v);
        return enh ? v : (v & ~8'h30);
    endfunction
    // modem inputs seen in loopback come from the modem control outputs
    function automatic modem_in_s loop_exp(input logic [7:0] m);
        return {~m[1], ~m[0], ~m[3], ~m[2]};
    endfunction
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (100000) @(posedge sys_clk);
        fail_count++;
        end_sim;
    end

    // main sequence
    initial begin
        rst = 1'b1;
        status = '0;
        repeat (12) @(posedge sys_clk);
        #2;
        rst = 1'b0;
        status = status_s'({$random(seed), 16'($random(seed))});
        rd(3'h3, 8'h00);
        rd(3'h1, 8'h00);
        rd(3'h0, status.receive_holding);
        rd(3'h2, isr_exp(1'b0, status.interrupt_status));
        rd(3'h5, status.line_status);
        rd(3'h6, status.modem_status);
        chk(rp_cnt, 4);
        c0 = cfg;
        wr(3'h5, 8'h5a);
        wr(3'h6, 8'ha5);
        chk(cfg, c0);
        r = $random(seed);
        wr(3'h0, r);
        chk(tx_cnt, 1);
        chk(last_wb, r);
        repeat (4) begin
            r = $random(seed);
            wr(3'h7, r);
            rd(3'h7, r);
        end
        u_host_bus_model.xfer(1'b1, 1'b0, 3'h7, ~r, junk);
        rd(3'h7, r);
        wr(3'h1, 8'hff);
        rd(3'h1, 8'h0f);
        wr(3'h2, 8'hff);
        chk(last_fc, 8'hcf);
        wr(3'h3, 8'h80);
        rd(3'h0, REV);
        rd(3'h1, DID);
        wr(3'h0, r | 8'h01);
        rd(3'h0, r | 8'h01);
        wr(3'h1, ~r);
        rd(3'h1, ~r);
        rd(3'h3, 8'h80);
        wr(3'h3, 8'hbf);
        wr(3'h2, 8'hd0);
        rd(3'h2, 8'hd0);
        wr(3'h1, 8'h40);
        rd(3'h1, 8'h40);
        for (int i = 4; i < 8; i++) begin
            x[i] = $random(seed);
            wr(3'(i), x[i]);
        end
        for (int i = 4; i < 8; i++) rd(3'(i), x[i]);
        rd(3'h0, status.fifo_level_count_enhanced);
        wr(3'h0, 8'h11);
        chk({tg_cnt, tx_cnt}, {32'd1, 32'd1});
        rd(3'h3, 8'hbf);
        wr(3'h3, 8'h03);
        rd(3'h7, status.fifo_level);
        wr(3'h7, ~r);
        chk(cfg.scratchpad, r);
        chk(ms_cnt, 1);
        wr(3'h1, 8'hff);
        rd(3'h1, 8'hff);
        rd(3'h2, isr_exp(1'b1, status.interrupt_status));
        wr(3'h2, 8'hff);
        chk(last_fc, 8'hff);
        wr(3'h4, 8'h13);
        rd(3'h4, 8'h13);
        repeat (16) begin
            @(negedge sys_clk);
            chk({tx_pin, rts_n, dtr_n}, 3'b111);
            chk(rx_shift_in, tx_shift_out);
            chk(modem_to_status, loop_exp(8'h13));
            chk({acts, arts}, 2'b00);
        end
        wr(3'h4, 8'h03);
        @(negedge sys_clk);
        chk({rts_n, dtr_n}, 2'b00);
        chk(tx_pin, tx_shift_out);
        chk(rx_shift_in, 1'b1);
        chk({acts, arts}, 2'b11);
        end_sim;
    end
endmodule
